// ==== inc/serial_ctrl_regs.vh ====
`ifndef SERIAL_CTRL_REGS_VH
`define SERIAL_CTRL_REGS_VH

`define OFS_CONTROL 8'h00
`define OFS_MODE 8'h04
`define OFS_POSITION 8'h08
`define OFS_TX_CTRL 8'h0c
`define OFS_RX_CTRL 8'h10
`define OFS_STATUS 8'h14
`define OFS_IRQ_EN 8'h18
`define OFS_TX_DATA 8'h1c

`define CTL_TX_EN 0
`define CTL_RX_EN 1
`define CTL_STOP 2
`define POS_CH0_LSB 0
`define POS_CH0_EN 8
`define POS_CH1_LSB 16
`define POS_CH1_EN 24
`define FL_TOP 3

`define ST_RSVD 15
`define ST_TX_CTRL_RDY 14
`define ST_TX_FIFO_EMPTY 13
`define ST_RX_CTRL_RDY 10

`define RST_WORD 32'h0000_0000
`define RST_STATUS 16'h0000
`define SLOT_LAST 4'hf

`endif

// ==== core/pin_sync.v ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // pin and filtered level
  input wire pin,
  output reg level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

// level changes once the two later stages agree
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    s1_r <= 1'b0;
    s2_r <= 1'b0;
    s3_r <= 1'b0;
    level_r <= 1'b0;
  end
  else
  begin
    s1_r <= pin;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (s2_r == s3_r)
      level_r <= s3_r;
  end
end

endmodule // pin_sync
`default_nettype wire

// ==== core/slot_shifter.v ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_regs.vh"
module slot_shifter (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // link events
  input wire bit_rise,
  input wire frame_sync,
  input wire rx_bit,
  // slot tracking
  output reg [3:0] bit_r,
  output reg [3:0] slot_r,
  output reg frame_start_r,
  // completed slot word
  output reg word_valid_r,
  output reg [3:0] word_slot_r,
  output reg [15:0] word_r
);

reg [15:0] sh_r;
reg [15:0] sh_nxt;
reg [3:0] cnt_now;
reg [3:0] slot_now;

always @*
begin
  sh_nxt = {sh_r[14:0], rx_bit};
  cnt_now = frame_sync ? 4'h0 : bit_r;
  slot_now = frame_sync ? 4'h0 : slot_r;
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    bit_r <= 4'h0;
    slot_r <= 4'h0;
    frame_start_r <= 1'b0;
    word_valid_r <= 1'b0;
    word_slot_r <= 4'h0;
    word_r <= 16'h0000;
    sh_r <= 16'h0000;
  end
  else
  begin
    frame_start_r <= bit_rise & frame_sync;
    word_valid_r <= 1'b0;
    if (bit_rise)
    begin
      sh_r <= sh_nxt;
      bit_r <= cnt_now + 4'h1;
      slot_r <= (cnt_now == `SLOT_LAST) ? slot_now + 4'h1 : slot_now;
      if (cnt_now == `SLOT_LAST)
      begin
        word_valid_r <= 1'b1;
        word_slot_r <= slot_now;
        word_r <= sh_nxt;
      end
    end
  end
end

endmodule // slot_shifter
`default_nettype wire

// ==== core/serial_ctrl_data_status.v ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_regs.vh"
module serial_ctrl_data_status (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // codec link pins
  input wire serial_clk_in,
  input wire frame_sync_in,
  input wire serial_rx_in,
  output reg serial_tx_out,
  // transmit fifo datapath
  input wire tx_fifo_drained,
  output reg tx_data_we,
  output reg [31:0] tx_data_word,
  // interrupt
  output reg irq
);

wire sck_lvl;
wire fs_lvl;
wire rxd_lvl;
reg sck_d_r;
wire bit_rise;
wire bit_fall;
wire [3:0] bit_idx;
wire [3:0] slot_idx;
wire frame_start;
wire word_valid;
wire [3:0] word_slot;
wire [15:0] word;

reg [2:0] control_reg_r;
reg [3:0] mode_reg_r;
reg [31:0] position_r;
reg [31:0] tx_control_data_r;
reg [31:0] tx_shadow_r;
reg tx_pending_r;
reg [31:0] rx_control_data_r;
reg [15:0] interrupt_enable_r;
reg tx_ctrl_ready_r;
reg tx_fifo_empty_r;
reg rx_ctrl_ready_r;

reg [15:0] status;
reg [31:0] rd_word;
reg addr_ok;
wire access;
wire wr;
wire rd;
wire stop;
wire ctrl_ok;
wire ch0_en;
wire ch1_en;
wire [3:0] ch0_pos;
wire [3:0] ch1_pos;
wire [15:0] tx_half;
wire [3:0] tx_pos;

function [15:0] slot_bit_pick;
  input [31:0] shadow;
  input ch0_hit;
  input ch1_hit;
  begin
    if (ch0_hit)
      slot_bit_pick = shadow[31:16];
    else if (ch1_hit)
      slot_bit_pick = shadow[15:0];
    else
      slot_bit_pick = 16'h0000;
  end
endfunction

pin_sync u_sync_sck (
  .pclk(pclk),
  .presetn(presetn),
  .pin(serial_clk_in),
  .level_r(sck_lvl)
);

pin_sync u_sync_fs (
  .pclk(pclk),
  .presetn(presetn),
  .pin(frame_sync_in),
  .level_r(fs_lvl)
);

pin_sync u_sync_rxd (
  .pclk(pclk),
  .presetn(presetn),
  .pin(serial_rx_in),
  .level_r(rxd_lvl)
);

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    sck_d_r <= 1'b0;
  else
    sck_d_r <= sck_lvl;
end

assign bit_rise = sck_lvl & ~sck_d_r;
assign bit_fall = ~sck_lvl & sck_d_r;

slot_shifter u_shift (
  .pclk(pclk),
  .presetn(presetn),
  .bit_rise(bit_rise),
  .frame_sync(fs_lvl),
  .rx_bit(rxd_lvl),
  .bit_r(bit_idx),
  .slot_r(slot_idx),
  .frame_start_r(frame_start),
  .word_valid_r(word_valid),
  .word_slot_r(word_slot),
  .word_r(word)
);

assign access = psel & penable & pready;
assign wr = access & pwrite;
assign rd = access & ~pwrite;
assign stop = control_reg_r[`CTL_STOP];
assign ctrl_ok = mode_reg_r[`FL_TOP];
assign ch0_en = position_r[`POS_CH0_EN];
assign ch1_en = position_r[`POS_CH1_EN];
assign ch0_pos = position_r[`POS_CH0_LSB+3:`POS_CH0_LSB];
assign ch1_pos = position_r[`POS_CH1_LSB+3:`POS_CH1_LSB];
assign tx_half = slot_bit_pick(tx_shadow_r, ch0_en & (slot_idx == ch0_pos),
                               ch1_en & (slot_idx == ch1_pos));
assign tx_pos = 4'hf - bit_idx;

always @*
begin
  status = `RST_STATUS;
  status[`ST_RSVD] = 1'b0;
  status[`ST_TX_CTRL_RDY] = tx_ctrl_ready_r;
  status[`ST_TX_FIFO_EMPTY] = tx_fifo_empty_r;
  status[`ST_RX_CTRL_RDY] = rx_ctrl_ready_r;
end

always @*
begin
  rd_word = 32'h0000_0000;
  addr_ok = 1'b1;
  case (paddr)
    `OFS_CONTROL: rd_word = {29'h0000_0000, control_reg_r};
    `OFS_MODE: rd_word = {28'h000_0000, mode_reg_r};
    `OFS_POSITION: rd_word = position_r;
    `OFS_TX_CTRL: rd_word = tx_control_data_r;
    `OFS_RX_CTRL: rd_word = rx_control_data_r;
    `OFS_STATUS: rd_word = {16'h0000, status};
    `OFS_IRQ_EN: rd_word = {16'h0000, interrupt_enable_r};
    `OFS_TX_DATA: rd_word = 32'h0000_0000;
    default: addr_ok = 1'b0;
  endcase
end

// apb: one wait-free access phase after setup
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pready <= 1'b0;
    prdata <= 32'h0000_0000;
    pslverr <= 1'b0;
  end
  else
  begin
    pready <= psel & ~penable;
    prdata <= (psel & ~penable & ~pwrite) ? rd_word : 32'h0000_0000;
    pslverr <= psel & ~penable & ~addr_ok;
  end
end

// configuration registers
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    control_reg_r <= 3'h0;
    mode_reg_r <= 4'h0;
    position_r <= `RST_WORD;
    interrupt_enable_r <= `RST_STATUS;
    tx_data_we <= 1'b0;
    tx_data_word <= `RST_WORD;
  end
  else
  begin
    tx_data_we <= 1'b0;
    if (wr & (paddr == `OFS_CONTROL))
      control_reg_r <= pwdata[2:0];
    if (wr & (paddr == `OFS_MODE))
      mode_reg_r <= pwdata[3:0];
    if (wr & (paddr == `OFS_POSITION))
      position_r <= pwdata & 32'h010f_010f;
    if (wr & (paddr == `OFS_IRQ_EN))
      interrupt_enable_r <= pwdata[15:0] & 16'h7fff;
    if (wr & (paddr == `OFS_TX_DATA))
    begin
      tx_data_we <= 1'b1;
      tx_data_word <= pwdata;
    end
  end
end

// transmit control data and its shadow
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    tx_control_data_r <= `RST_WORD;
    tx_shadow_r <= `RST_WORD;
    tx_pending_r <= 1'b0;
    tx_ctrl_ready_r <= 1'b0;
  end
  else if (stop)
  begin
    tx_control_data_r <= `RST_WORD;
    tx_shadow_r <= `RST_WORD;
    tx_pending_r <= 1'b0;
    tx_ctrl_ready_r <= 1'b0;
  end
  else
  begin
    if (frame_start & tx_pending_r & ctrl_ok)
    begin
      tx_shadow_r <= tx_control_data_r;
      tx_pending_r <= 1'b0;
    end
    if (wr & (paddr == `OFS_TX_CTRL))
    begin
      tx_control_data_r <= pwdata;
      tx_pending_r <= 1'b1;
    end
    if (!control_reg_r[`CTL_TX_EN])
      tx_ctrl_ready_r <= 1'b0;
    else if (frame_start & ctrl_ok & (tx_pending_r | ~tx_ctrl_ready_r))
      tx_ctrl_ready_r <= 1'b1;
    else if (wr & (paddr == `OFS_TX_CTRL))
      tx_ctrl_ready_r <= 1'b0;
  end
end

// receive capture and status flags
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    rx_control_data_r <= `RST_WORD;
    rx_ctrl_ready_r <= 1'b0;
    tx_fifo_empty_r <= 1'b0;
  end
  else if (stop)
  begin
    rx_control_data_r <= `RST_WORD;
    rx_ctrl_ready_r <= 1'b0;
    tx_fifo_empty_r <= 1'b0;
  end
  else
  begin
    if (word_valid & ctrl_ok & ch0_en & (word_slot == ch0_pos))
      rx_control_data_r[31:16] <= word;
    if (word_valid & ctrl_ok & ch1_en & (word_slot == ch1_pos))
      rx_control_data_r[15:0] <= word;
    if (word_valid & ctrl_ok & control_reg_r[`CTL_RX_EN] &
        ((ch0_en & (word_slot == ch0_pos)) | (ch1_en & (word_slot == ch1_pos))))
      rx_ctrl_ready_r <= 1'b1;
    else if (rd & (paddr == `OFS_RX_CTRL))
      rx_ctrl_ready_r <= 1'b0;
    if (!control_reg_r[`CTL_TX_EN])
      tx_fifo_empty_r <= 1'b0;
    else if (tx_fifo_drained)
      tx_fifo_empty_r <= 1'b1;
    else if (wr & (paddr == `OFS_TX_DATA))
      tx_fifo_empty_r <= 1'b0;
  end
end

// transmit pin driven on falling bit clock
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    serial_tx_out <= 1'b0;
  else if (stop | ~control_reg_r[`CTL_TX_EN] | ~ctrl_ok)
    serial_tx_out <= 1'b0;
  else if (bit_fall)
    serial_tx_out <= tx_half[tx_pos];
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    irq <= 1'b0;
  else
    irq <= |(status & interrupt_enable_r);
end

endmodule // serial_ctrl_data_status
`default_nettype wire

// ==== sim/serial_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // datapath and interrupt
  input wire logic tx_data_we,
  input wire logic [31:0] tx_data_word,
  input wire logic irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire acc = psel && penable && pready;
  chk_ready_once: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single cycle");
  chk_err_unmapped: assert property (setup && paddr > 8'h1c |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  chk_idle_quiet: assert property (!pready |-> !pslverr && prdata == 0)
    else $error("bus outputs busy outside access");
  chk_status_rsvd: assert property (
    acc && !pwrite && paddr == 8'h14 |-> prdata[31:15] == 0)
    else $error("status upper bits not zero");
  chk_txdata_pulse: assert property (
    acc && pwrite && paddr == 8'h1c |=> tx_data_we && tx_data_word == $past(pwdata))
    else $error("transmit data not handed on");
  chk_we_single: assert property (tx_data_we |=> !tx_data_we)
    else $error("transmit write pulse too long");
  chk_mask_off: assert property (
    acc && pwrite && paddr == 8'h18 && pwdata[15:0] == 0 |-> ##2 !irq)
    else $error("interrupt with all sources masked");
  chk_stop_clears: assert property (
    acc && pwrite && paddr == 8'h00 && pwdata[2] |-> ##3 !irq)
    else $error("interrupt survives module stop");
  chk_reset_quiet: assert property ($rose(presetn) |-> !pready && !irq)
    else $error("outputs active after reset");
  cover property (acc && !pwrite && paddr == 8'h10);
  cover property (irq);
  cover property (tx_data_we);
endmodule // serial_ctrl_monitor
bind serial_ctrl_data_status serial_ctrl_monitor mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_data_we, .tx_data_word, .irq);
`default_nettype wire

// ==== sim/codec_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module codec_model (
  // link pins
  output logic serial_clk_in,
  output logic frame_sync_in,
  output logic serial_rx_in,
  input wire logic serial_tx_out
);
  logic [63:0] tx_seen = 0;
  initial
  begin
    serial_clk_in = 0;
    frame_sync_in = 0;
    serial_rx_in = 0;
  end
  // four slots, msb first; clock stands still between frames
  task automatic send_frame(input logic [63:0] w, input int half);
    int i;
    for (i = 63; i >= 0; i--)
    begin
      serial_rx_in = w[i];
      frame_sync_in = (i == 63);
      #(half);
      serial_clk_in = 1;
      tx_seen = {tx_seen[62:0], serial_tx_out};
      #(half);
      serial_clk_in = 0;
    end
    frame_sync_in = 0;
    serial_rx_in = ~serial_rx_in;
  endtask
endmodule // codec_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctrl_regs.vh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_fifo_drained = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, seed = 32'h2a32e413, a, b;
  logic [31:0] prdata, tx_data_word;
  logic pready, pslverr, tx_data_we, irq;
  logic serial_clk_in, frame_sync_in, serial_rx_in, serial_tx_out;
  logic [31:0] expq[$];
  int errors = 0, tests_run = 0;
  always #25 pclk = ~pclk;
  serial_ctrl_data_status DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_clk_in, .frame_sync_in, .serial_rx_in,
    .serial_tx_out, .tx_fifo_drained, .tx_data_we, .tx_data_word, .irq);
  codec_model codec (.serial_clk_in, .frame_sync_in, .serial_rx_in, .serial_tx_out);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    expq.push_back(exp);
    apb(0, ad, 0);
  endtask
  task automatic drain_pulse;
    tx_fifo_drained <= 1;
    @(posedge pclk);
    tx_fifo_drained <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic end_sim;
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // read results against oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check(prdata, expq.pop_front());
  initial
  begin
    #2_000_000;
    errors++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`OFS_RX_CTRL, 0);
    apb(1, `OFS_STATUS, 32'h0000_6400);
    rd(`OFS_STATUS, 0);
    rd(8'h20, 0);
    apb(1, `OFS_CONTROL, 32'h3);
    apb(1, `OFS_MODE, 32'h8);
    apb(1, `OFS_POSITION, 32'h0102_0101);
    apb(1, `OFS_IRQ_EN, 32'h2000);
    drain_pulse;
    check(irq, 1);
    rd(`OFS_STATUS, 32'h2000);
    apb(1, `OFS_IRQ_EN, 0);
    repeat (3) @(posedge pclk);
    check(irq, 0);
    apb(1, `OFS_CONTROL, 32'h2);
    rd(`OFS_STATUS, 0);
    apb(1, `OFS_CONTROL, 32'h3);
    drain_pulse;
    a = xs(seed);
    apb(1, `OFS_TX_DATA, a);
    rd(`OFS_STATUS, 0);
    b = xs(a);
    apb(1, `OFS_TX_CTRL, a);
    apb(1, `OFS_TX_CTRL, b);
    rd(`OFS_TX_CTRL, b);
    seed = xs(b);
    codec.send_frame({16'h0, seed, 16'h0}, 500);
    repeat (20) @(posedge pclk);
    check(codec.tx_seen[47:16], b);
    rd(`OFS_STATUS, 32'h4400);
    rd(`OFS_RX_CTRL, seed);
    apb(1, `OFS_CONTROL, 32'h2);
    rd(`OFS_STATUS, 0);
    apb(1, `OFS_CONTROL, 32'h3);
    codec.send_frame({16'h0, seed, 16'h0}, 500);
    repeat (20) @(posedge pclk);
    rd(`OFS_STATUS, 32'h4400);
    rd(`OFS_RX_CTRL, seed);
    apb(1, `OFS_TX_CTRL, 0);
    rd(`OFS_STATUS, 0);
    apb(1, `OFS_IRQ_EN, 32'h2000);
    drain_pulse;
    apb(1, `OFS_CONTROL, 32'h7);
    rd(`OFS_STATUS, 0);
    check(irq, 0);
    apb(1, `OFS_CONTROL, 32'h3);
    apb(1, `OFS_MODE, 0);
    codec.send_frame({16'h0, xs(seed), 16'h0}, 1200);
    repeat (20) @(posedge pclk);
    rd(`OFS_RX_CTRL, 0);
    end_sim;
  end
endmodule // tb
`default_nettype wire
